/* verilog/adc_seq_pkg.sv */
// Purpose: Shared constants and types for the converter sequencer
// Assumes: Byte offsets on a 32-bit classic Wishbone bus
// Notes: One register per aligned word
package adc_seq_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_UPPER = 8'h0C;
  localparam logic [7:0] OFF_LOWER = 8'h10;
  localparam logic [7:0] OFF_CHAN = 8'h14;
  localparam logic [7:0] OFF_RES_HI = 8'h18;
  localparam logic [7:0] OFF_RES_LO = 8'h1C;
  // Control word fields
  localparam int CTRL_PWR = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_REPEAT = 2;
  localparam int CTRL_EOC_IE = 3;
  localparam int CTRL_ALARM_IE = 4;
  localparam int CTRL_RES_LSB = 5;
  localparam int CTRL_OVR_IE = 7;
  // Config word fields
  localparam int CFG_HALVE = 0;
  localparam int CFG_ACH_LSB = 8;
  // Status word fields
  localparam int STAT_EOC = 0;
  localparam int STAT_ALARM = 1;
  localparam int STAT_OVR = 2;
  localparam int STAT_BUSY = 3;
  localparam int CHAN_DMA_OFF = 31;
  // Resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;
  localparam logic [11:0] UPPER_RESET = 12'h0FFF;
  localparam logic [11:0] LOWER_RESET = 12'h0000;
  localparam int SETTLE_TICKS = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_NEXT = 2'b11
  } state_type;
  typedef struct packed {
    logic overrun;
    logic alarm;
    logic eoc;
  } flags_type;
endpackage : adc_seq_pkg

/* verilog/adc_sequencer_control.sv */
// Purpose: SAR sequencing, watchdog, DMA request and result registers
// Assumes: Comparator high means input above the trial code
// Notes: Registers reached over classic Wishbone, 32-bit data
// What this block does
// - Continuous mode steps channels while repeat and power bits stay set.
// - End-of-conversion flag rises only when the sequence's last channel ends.
// - Clearing repeat mid-sequence finishes through last channel, then halts; with DMA disabled it halts after the current channel.
// - Converter clock is source clock or half of it, one select bit.
// - Alarm flag sets when result is above upper or below lower limit.
// - In scan mode only the selected alarm channel is compared.
// - Alarm flag never stops the rest of a scan sequence.
// - Overrun flags when a scan result lands while DMA still pending.
// - Separate interrupt per event plus one combined interrupt.
// - Single scan with DMA converts the list once, then needs restart.
// - Channel list is a bitmask, bit n selects channel n.
// - Repeat mode restarts from first selected channel after the last.
// - Each scan conversion end raises a DMA request.
// - DMA disable suppresses requests; single mode converts highest channel only.
// - High-byte read copies low byte to shadow; next low read returns it.
// - Resolution selects 6/8/10/12 bits; conversion ends at chosen count.
// - Results are right aligned with zero fill.
// - Resolution codes 00=12, 01=10, 10=8, 11=6 bits.
// - End flag clears by software write or by low-byte read.
`timescale 1ns/100ps
module adc_sequencer_control #(
  parameter int CHANNELS = 28,
  parameter int SETTLE = adc_seq_pkg::SETTLE_TICKS
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic cmp_i, // Analog comparator pin
  output logic [11:0] dac_code_o, // Trial code
  output logic [4:0] channel_o, // Channel being converted
  output logic power_o, // Converter powered
  output logic dma_req_o, // Result ready for DMA
  input wire logic dma_ack_i, // DMA took the result
  output logic [15:0] dma_data_o, // Result word
  output logic eoc_irq_o, // End-of-conversion interrupt
  output logic alarm_irq_o, // Watchdog interrupt
  output logic overrun_irq_o, // Overrun interrupt
  output logic irq_o // Combined interrupt
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 31) $error("CHANNELS out of range");
    // Two comparator sync stages need three ticks per trial bit
    if (SETTLE < 3 || SETTLE > 15) $error("SETTLE out of range");
  end

  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE - 1);

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = (old & ~lane_mask(sel)) | (dat & lane_mask(sel));
  endfunction : merge

  // Lowest selected channel at or above lo; bit 5 flags a hit
  function automatic logic [5:0] first_from(input logic [CHANNELS-1:0] m,
                                            input logic [5:0] lo);
    first_from = 6'h00;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (m[i] && 6'(i) >= lo) first_from = {1'b1, 5'(i)};
    end
  endfunction : first_from

  function automatic logic [5:0] highest(input logic [CHANNELS-1:0] m);
    highest = 6'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      if (m[i]) highest = {1'b1, 5'(i)};
    end
  endfunction : highest

  // Converter state
  adc_seq_pkg::state_type state_q;
  logic busy;
  assign busy = (state_q != adc_seq_pkg::ST_IDLE);

  // Register bus
  logic req, wr, rd;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  logic [7:0] ctrl_q, shadow_q;
  logic [31:0] cfg_q, chan_q;
  logic [11:0] upper_q, lower_q;
  logic start_q, shadow_full_q;
  adc_seq_pkg::flags_type flags_q;
  logic [15:0] result_q;

  logic pwr, repeat_on, dma_off, scan;
  logic [1:0] res_sel;
  logic [CHANNELS-1:0] mask;
  assign pwr = ctrl_q[adc_seq_pkg::CTRL_PWR];
  assign repeat_on = ctrl_q[adc_seq_pkg::CTRL_REPEAT];
  assign res_sel = ctrl_q[adc_seq_pkg::CTRL_RES_LSB +: 2];
  assign dma_off = chan_q[adc_seq_pkg::CHAN_DMA_OFF];
  assign mask = chan_q[CHANNELS-1:0];
  assign scan = repeat_on | ~dma_off;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      cfg_q <= 32'h0000_0000;
      upper_q <= adc_seq_pkg::UPPER_RESET;
      lower_q <= adc_seq_pkg::LOWER_RESET;
      chan_q <= 32'h0000_0000;
    end else if (wr) begin
      case (wb_adr_i)
        adc_seq_pkg::OFF_CTRL: begin
          ctrl_q <= 8'(merge({24'h00_0000, ctrl_q}, wb_dat_i, wb_sel_i));
          ctrl_q[adc_seq_pkg::CTRL_START] <= 1'b0;
        end
        adc_seq_pkg::OFF_CFG: cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i) & 32'h0000_1F01;
        adc_seq_pkg::OFF_UPPER: upper_q <= 12'(merge({20'h0_0000, upper_q}, wb_dat_i, wb_sel_i));
        adc_seq_pkg::OFF_LOWER: lower_q <= 12'(merge({20'h0_0000, lower_q}, wb_dat_i, wb_sel_i));
        adc_seq_pkg::OFF_CHAN: chan_q <= merge(chan_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Start pulse; ignored while busy or powered down
  logic start_wr;
  assign start_wr = wr && wb_adr_i == adc_seq_pkg::OFF_CTRL && wb_sel_i[0]
                    && wb_dat_i[adc_seq_pkg::CTRL_START];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_wr & pwr & ~busy;
    end
  end

  // Converter tick: every cycle or every other cycle
  logic tick_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= 1'b0;
    end else if (cfg_q[adc_seq_pkg::CFG_HALVE]) begin
      tick_q <= ~tick_q;
    end else begin
      tick_q <= 1'b1;
    end
  end

  // Comparator synchroniser
  logic cmp_meta_q, cmp_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_i;
      cmp_q <= cmp_meta_q;
    end
  end

  // Successive approximation and sequencing
  logic [3:0] bit_q, wait_q, last_bit;
  logic [11:0] trial, kept;
  logic [5:0] nxt, first_sel;
  logic conv_end;
  assign trial = 12'h001 << bit_q;
  assign kept = cmp_q ? dac_code_o : (dac_code_o & ~trial);
  assign last_bit = {1'b0, res_sel, 1'b0};
  assign conv_end = state_q == adc_seq_pkg::ST_CONV && tick_q
                    && wait_q == SETTLE_LAST && bit_q == last_bit;
  assign nxt = first_from(mask, 6'(channel_o) + 6'h01);
  assign first_sel = scan ? first_from(mask, 6'h00) : highest(mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= adc_seq_pkg::ST_IDLE;
      bit_q <= 4'hB;
      wait_q <= 4'h0;
      dac_code_o <= 12'h000;
      channel_o <= 5'h00;
    end else if (!pwr) begin
      state_q <= adc_seq_pkg::ST_IDLE;
      dac_code_o <= 12'h000;
    end else begin
      case (state_q)
        adc_seq_pkg::ST_IDLE: begin
          if (start_q) begin
            state_q <= adc_seq_pkg::ST_CONV;
            channel_o <= first_sel[4:0];
            bit_q <= 4'hB;
            wait_q <= 4'h0;
            dac_code_o <= 12'h800;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (tick_q) begin
            if (wait_q != SETTLE_LAST) begin
              wait_q <= wait_q + 4'h1;
            end else if (bit_q == last_bit) begin
              dac_code_o <= kept;
              state_q <= adc_seq_pkg::ST_NEXT;
            end else begin
              wait_q <= 4'h0;
              bit_q <= bit_q - 4'h1;
              dac_code_o <= kept | (trial >> 1);
            end
          end
        end
        adc_seq_pkg::ST_NEXT: begin
          bit_q <= 4'hB;
          wait_q <= 4'h0;
          dac_code_o <= 12'h800;
          if (scan && nxt[5]) begin
            channel_o <= nxt[4:0];
            state_q <= adc_seq_pkg::ST_CONV;
          end else if (repeat_on) begin
            channel_o <= first_sel[4:0];
            state_q <= adc_seq_pkg::ST_CONV;
          end else begin
            state_q <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result store, right aligned
  logic [11:0] aligned;
  assign aligned = kept >> last_bit;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= 16'h0000;
    end else if (conv_end) begin
      result_q <= {4'h0, aligned};
    end
  end
  assign dma_data_o = result_q;

  // Event detection
  logic seq_end, alarm_hit;
  logic [4:0] alarm_chan;
  assign alarm_chan = cfg_q[adc_seq_pkg::CFG_ACH_LSB +: 5];
  assign seq_end = state_q == adc_seq_pkg::ST_NEXT && !(scan && nxt[5]);
  assign alarm_hit = conv_end && (!scan || channel_o == alarm_chan)
                     && (aligned > upper_q || aligned < lower_q);

  logic stat_wr, lo_rd, hi_rd;
  assign stat_wr = wr && wb_adr_i == adc_seq_pkg::OFF_STAT && wb_sel_i[0];
  assign lo_rd = rd && wb_adr_i == adc_seq_pkg::OFF_RES_LO;
  assign hi_rd = rd && wb_adr_i == adc_seq_pkg::OFF_RES_HI;

  // Flags: write one clears, a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      if (seq_end) begin
        flags_q.eoc <= 1'b1;
      end else if (lo_rd || (stat_wr && wb_dat_i[adc_seq_pkg::STAT_EOC])) begin
        flags_q.eoc <= 1'b0;
      end
      if (alarm_hit) begin
        flags_q.alarm <= 1'b1;
      end else if (stat_wr && wb_dat_i[adc_seq_pkg::STAT_ALARM]) begin
        flags_q.alarm <= 1'b0;
      end
      if (conv_end && scan && !dma_off && dma_req_o && !dma_ack_i) begin
        flags_q.overrun <= 1'b1;
      end else if (stat_wr && wb_dat_i[adc_seq_pkg::STAT_OVR]) begin
        flags_q.overrun <= 1'b0;
      end
    end
  end

  // DMA request per scan conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_req_o <= 1'b0;
    end else if (conv_end && scan && !dma_off) begin
      dma_req_o <= 1'b1;
    end else if (dma_ack_i) begin
      dma_req_o <= 1'b0;
    end
  end

  // Interrupt lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc_irq_o <= 1'b0;
      alarm_irq_o <= 1'b0;
      overrun_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      eoc_irq_o <= flags_q.eoc & ctrl_q[adc_seq_pkg::CTRL_EOC_IE];
      alarm_irq_o <= flags_q.alarm & ctrl_q[adc_seq_pkg::CTRL_ALARM_IE];
      overrun_irq_o <= flags_q.overrun & ctrl_q[adc_seq_pkg::CTRL_OVR_IE];
      irq_o <= eoc_irq_o | alarm_irq_o | overrun_irq_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_o <= 1'b0;
    end else begin
      power_o <= pwr;
    end
  end

  // Low-byte shadow for consistent two-part reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_q <= 8'h00;
      shadow_full_q <= 1'b0;
    end else if (hi_rd) begin
      shadow_q <= result_q[7:0];
      shadow_full_q <= 1'b1;
    end else if (lo_rd) begin
      shadow_full_q <= 1'b0;
    end
  end

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        adc_seq_pkg::OFF_CTRL: wb_dat_o <= {24'h00_0000, ctrl_q};
        adc_seq_pkg::OFF_CFG: wb_dat_o <= cfg_q;
        adc_seq_pkg::OFF_STAT: wb_dat_o <= {28'h000_0000, busy, flags_q};
        adc_seq_pkg::OFF_UPPER: wb_dat_o <= {20'h0_0000, upper_q};
        adc_seq_pkg::OFF_LOWER: wb_dat_o <= {20'h0_0000, lower_q};
        adc_seq_pkg::OFF_CHAN: wb_dat_o <= chan_q;
        adc_seq_pkg::OFF_RES_HI: wb_dat_o <= {24'h00_0000, result_q[15:8]};
        adc_seq_pkg::OFF_RES_LO: begin
          wb_dat_o <= {24'h00_0000, shadow_full_q ? shadow_q : result_q[7:0]};
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : adc_sequencer_control

/* dv/adc_sequencer_control_asserts.sv */
// Purpose: Port-level checks for the converter sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every sequencer instance
`timescale 1ns/100ps
module adc_sequencer_control_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic dma_req_o, // DMA request
  input wire logic dma_ack_i, // DMA acknowledge
  input wire logic [15:0] dma_data_o, // Result word
  input wire logic eoc_irq_o, // End interrupt
  input wire logic alarm_irq_o, // Alarm interrupt
  input wire logic overrun_irq_o, // Overrun interrupt
  input wire logic irq_o // Combined interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped_zero;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h1C |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_hi_fill;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == adc_seq_pkg::OFF_RES_HI
      |-> wb_dat_o[31:4] == 28'h0;
  endproperty
  a_hi_fill: assert property (p_hi_fill) else $error("high byte fill");
  property p_lo_width;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == adc_seq_pkg::OFF_RES_LO
      |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_lo_width: assert property (p_lo_width) else $error("low byte width");
  property p_dma_word;
    dma_req_o |-> dma_data_o[15:12] == 4'h0;
  endproperty
  a_dma_word: assert property (p_dma_word) else $error("result word fill");
  property p_req_hold;
    dma_req_o && !dma_ack_i |=> dma_req_o;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_irq_comb;
    irq_o == $past(eoc_irq_o || alarm_irq_o || overrun_irq_o);
  endproperty
  a_irq_comb: assert property (p_irq_comb) else $error("combined irq");
endmodule : adc_sequencer_control_asserts
bind adc_sequencer_control adc_sequencer_control_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i),
  .dma_data_o(dma_data_o), .eoc_irq_o(eoc_irq_o), .alarm_irq_o(alarm_irq_o),
  .overrun_irq_o(overrun_irq_o), .irq_o(irq_o));

/* dv/dma_drain_model.sv */
// Purpose: DMA controller stand-in draining result words
// Assumes: Acknowledge is a one-cycle pulse
// Notes: Stalls delay_i cycles before each acknowledge
`timescale 1ns/100ps
module dma_drain_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic req_i, // Result ready
  input wire logic [15:0] data_i, // Result word
  input wire logic [7:0] delay_i, // Stall cycles
  output logic ack_o // Result taken
);
  logic [15:0] log_q [0:63];
  int count_q;
  logic [7:0] wait_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      count_q <= 0;
      wait_q <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      // Skip the cycle of our own ack: request is still seen high there
      if (req_i && !ack_o) begin
        if (wait_q >= delay_i) begin
          ack_o <= 1'b1;
          log_q[count_q[5:0]] <= data_i;
          count_q <= count_q + 1;
          wait_q <= 8'h00;
        end else begin
          wait_q <= wait_q + 8'h01;
        end
      end
    end
  end
endmodule : dma_drain_model

/* dv/tb_adc_sequencer_control.sv */
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Channel n input level is {n, n, 4'hC} from its low nibble
// Notes: Tests are Wishbone register call sequences
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_adc_sequencer_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00, dly = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rdat;
  logic wb_ack, dma_ack, req, eoc, alm, ovr, irq, pwr;
  logic [11:0] dac, lvl, expv;
  logic [4:0] chan;
  logic [15:0] dword;
  logic [15:0] tbl [0:2];
  int failures = 0;
  int checks_done = 0;
  int base;
  int cyc_n = 0;
  int t0, span;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  assign lvl = {chan[3:0], chan[3:0], 4'hC};
  adc_sequencer_control #(.CHANNELS(28), .SETTLE(3)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cmp_i(lvl >= dac), .dac_code_o(dac), .channel_o(chan), .power_o(pwr),
    .dma_req_o(req), .dma_ack_i(dma_ack), .dma_data_o(dword), .eoc_irq_o(eoc),
    .alarm_irq_o(alm), .overrun_irq_o(ovr), .irq_o(irq));
  dma_drain_model dma (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .data_i(dword),
    .delay_i(dly), .ack_o(dma_ack));
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wbx
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wbx(1'b0, adc_seq_pkg::OFF_STAT, 32'h0);
      n++;
    end while (rdat[b] !== v && n < 400);
    `CHK("status_bit", v, rdat[b])
  endtask : poll
  task automatic hilo(input logic [31:0] hi, input logic [31:0] lo);
    wbx(1'b0, adc_seq_pkg::OFF_RES_HI, 32'h0);
    `CHK("result_high", hi, rdat)
    wbx(1'b0, adc_seq_pkg::OFF_RES_LO, 32'h0);
    `CHK("result_low", lo, rdat)
  endtask : hilo
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    #2_400_000;
    failures++;
    end_sim();
  end
  initial begin
    tbl[0] = 16'h011C;
    tbl[1] = 16'h044C;
    tbl[2] = 16'h066C;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wbx(1'b0, adc_seq_pkg::OFF_UPPER, 32'h0);
    `CHK("upper_reset", 32'h0000_0FFF, rdat)
    wbx(1'b1, 8'h40, 32'hFFFF_FFFF);
    wbx(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    $display("test registers done");
    wbx(1'b1, adc_seq_pkg::OFF_CHAN, 32'h8000_0208);
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_0099);
    `CHK("power_on", 1'b1, pwr)
    for (int c = 0; c < 4; c++) begin
      expv = 12'h99C >> (2 * c);
      wbx(1'b1, adc_seq_pkg::OFF_CFG, 32'(c & 1));
      wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009B | 32'(c << 5));
      t0 = cyc_n;
      poll(adc_seq_pkg::STAT_EOC, 1'b1);
      // Settle ticks per bit, doubled when the converter clock is halved
      span = adc_seq_pkg::SETTLE_TICKS * (12 - 2 * c) * (1 + (c & 1));
      `CHK("conv_cycles", 1'b1, cyc_n - t0 >= span && cyc_n - t0 <= span + 4)
      `CHK("eoc_irq", 1'b1, eoc)
      `CHK("no_dma", 1'b0, req)
      hilo({28'h0, expv[11:8]}, {24'h0, expv[7:0]});
      poll(adc_seq_pkg::STAT_EOC, 1'b0);
    end
    $display("test resolution done");
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009B);
    poll(adc_seq_pkg::STAT_EOC, 1'b1);
    wbx(1'b0, adc_seq_pkg::OFF_RES_HI, 32'h0);
    wbx(1'b1, adc_seq_pkg::OFF_CHAN, 32'h8000_0010);
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009B);
    poll(adc_seq_pkg::STAT_BUSY, 1'b1);
    poll(adc_seq_pkg::STAT_BUSY, 1'b0);
    wbx(1'b0, adc_seq_pkg::OFF_RES_LO, 32'h0);
    `CHK("shadow_low", 32'h0000_009C, rdat)
    hilo(32'h0000_0004, 32'h0000_004C);
    $display("test shadow done");
    wbx(1'b1, adc_seq_pkg::OFF_UPPER, 32'h0000_0500);
    wbx(1'b1, adc_seq_pkg::OFF_LOWER, 32'h0000_0100);
    wbx(1'b1, adc_seq_pkg::OFF_CHAN, 32'h0000_0052);
    for (int r = 0; r < 2; r++) begin
      // Alarm watches channel 4 (in range), then channel 6 (above)
      wbx(1'b1, adc_seq_pkg::OFF_CFG, 32'h0000_0400 + 32'(r * 512));
      wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009B);
      poll(adc_seq_pkg::STAT_EOC, 1'b1);
      `CHK("eoc_late", 1'b1, dma.count_q >= 3 * r + 2)
      `CHK("alarm", r[0], rdat[adc_seq_pkg::STAT_ALARM])
      `CHK("alarm_irq", r[0], alm)
      poll(adc_seq_pkg::STAT_BUSY, 1'b0);
      repeat (3) @(posedge clk_i);
      `CHK("words", 3 * r + 3, dma.count_q)
      for (int k = 0; k < 3; k++) `CHK("dma_word", tbl[k], dma.log_q[3 * r + k])
      wbx(1'b1, adc_seq_pkg::OFF_STAT, 32'h0000_0007);
    end
    $display("test scan done");
    dly <= 8'hC8;
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009B);
    poll(adc_seq_pkg::STAT_OVR, 1'b1);
    @(posedge clk_i);
    `CHK("ovr_irq", 1'b1, ovr)
    `CHK("irq", 1'b1, irq)
    poll(adc_seq_pkg::STAT_BUSY, 1'b0);
    dly <= 8'h00;
    $display("test overrun done");
    wbx(1'b1, adc_seq_pkg::OFF_STAT, 32'h0000_0007);
    wbx(1'b1, adc_seq_pkg::OFF_CHAN, 32'h0000_0012);
    base = dma.count_q;
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_009F);
    for (int n = 0; n < 3000 && dma.count_q < base + 5; n++) @(posedge clk_i);
    // Repeat is only ever cleared here, never set again while busy
    wbx(1'b1, adc_seq_pkg::OFF_CTRL, 32'h0000_0099);
    poll(adc_seq_pkg::STAT_BUSY, 1'b0);
    repeat (3) @(posedge clk_i);
    `CHK("whole_lists", 1'b0, 1'(dma.count_q - base))
    `CHK("last_word", 16'h044C, dma.log_q[dma.count_q - 1])
    `CHK("wrap_word", 16'h011C, dma.log_q[base + 2])
    `CHK("list_eoc", 1'b1, eoc)
    $display("test continuous done");
    end_sim();
  end
endmodule : tb_adc_sequencer_control
